/* File: core/bitop_pkg.sv */
// Package for the bit-oriented instruction unit: encodings and widths.
// Assumes a 12-bit instruction word and a 5-bit file register address of 8-bit registers.
package bitop_pkg;
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned BITSEL_W = 3;
  localparam int unsigned OPC_MSB = 11;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned BITSEL_MSB = 7;
  localparam int unsigned BITSEL_LSB = 5;
  localparam int unsigned FADDR_MSB = 4;
  localparam int unsigned FADDR_LSB = 0;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam logic [3:0] OPC_TEST_CLEAR = 4'h6;
  localparam logic [3:0] OPC_TEST_SET = 4'h7;
  localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
  localparam logic [DATA_W-1:0] WDATA_RST = 8'h00;

  typedef enum logic [2:0] {
    BITOP_NONE,
    BITOP_BIT_CLEAR,
    BITOP_BIT_SET,
    BITOP_TEST_CLEAR,
    BITOP_TEST_SET
  } bitop_op_t;
endpackage

/* File: core/bitop_decode.sv */
// Instruction decoder: splits a 12-bit word into operation and operands.
// Assumes a purely combinational use from the same clock domain.
`timescale 1ns/1ps
module bitop_decode (
  // Instruction word.
  input wire logic [bitop_pkg::INSTR_W-1:0] instr_i,
  // Decoded fields.
  output bitop_pkg::bitop_op_t op_o,
  output logic [bitop_pkg::BITSEL_W-1:0] bit_sel_o,
  output logic [bitop_pkg::FADDR_W-1:0] faddr_o
);
  import bitop_pkg::*;

  always_comb begin
    bit_sel_o = instr_i[BITSEL_MSB:BITSEL_LSB];
    faddr_o = instr_i[FADDR_MSB:FADDR_LSB];
    case (instr_i[OPC_MSB:OPC_LSB])
      OPC_BIT_CLEAR: begin
        op_o = BITOP_BIT_CLEAR;
      end
      OPC_BIT_SET: begin
        op_o = BITOP_BIT_SET;
      end
      OPC_TEST_CLEAR: begin
        op_o = BITOP_TEST_CLEAR;
      end
      OPC_TEST_SET: begin
        op_o = BITOP_TEST_SET;
      end
      default: begin
        op_o = BITOP_NONE;
      end
    endcase
  end
endmodule // bitop_decode

/* File: core/bitop_unit.sv */
// Bit-oriented instruction unit: clear, set, and test-with-skip of a bit.
// Assumes the core presents one instruction per enabled cycle, and a file
// register read port that answers combinationally in the same cycle.
`timescale 1ns/1ps
module bitop_unit (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Instruction input.
  input wire logic instr_valid_i,
  input wire logic [bitop_pkg::INSTR_W-1:0] instr_i,
  // File register read port.
  output logic [bitop_pkg::FADDR_W-1:0] rd_addr_o,
  input wire logic [bitop_pkg::DATA_W-1:0] rd_data_i,
  // File register write port.
  output logic wr_en_o,
  output logic [bitop_pkg::FADDR_W-1:0] wr_addr_o,
  output logic [bitop_pkg::DATA_W-1:0] wr_data_o,
  // Sequencing.
  output logic skip_o,
  output logic nop_cycle_o,
  output logic busy_o
);
  import bitop_pkg::*;

  typedef struct packed {
    logic wr_en;
    logic [FADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic skip;
    logic nop_cycle;
  } bitop_state_t;

  bitop_state_t st;
  bitop_state_t next_st;
  bitop_op_t op;
  logic [BITSEL_W-1:0] bit_sel;
  logic [FADDR_W-1:0] faddr;
  logic tested_bit;
  logic take;
  logic [DATA_W-1:0] bit_mask;

  bitop_decode u_decode (
    .instr_i(instr_i),
    .op_o(op),
    .bit_sel_o(bit_sel),
    .faddr_o(faddr)
  );

  // The operand register is read in the same cycle as the instruction.
  assign rd_addr_o = faddr;
  assign tested_bit = |(rd_data_i & bit_mask);

  // One select line per bit position of the operand byte.
  for (genvar b = 0; b < DATA_W; b++) begin : g_mask
    assign bit_mask[b] = (bit_sel == BITSEL_W'(b));
  end
  // A word arriving during the flush cycle is the discarded prefetch.
  assign take = clk_en_i && instr_valid_i && !st.skip;

  always_comb begin
    next_st = st;
    next_st.wr_en = 1'b0;
    next_st.skip = 1'b0;
    next_st.nop_cycle = st.skip;
    if (take) begin
      case (op)
        BITOP_BIT_CLEAR: begin
          next_st.wr_en = 1'b1;
          next_st.wr_addr = faddr;
          next_st.wr_data = rd_data_i & ~bit_mask;
        end
        BITOP_BIT_SET: begin
          next_st.wr_en = 1'b1;
          next_st.wr_addr = faddr;
          next_st.wr_data = rd_data_i | bit_mask;
        end
        BITOP_TEST_CLEAR: begin
          next_st.skip = !tested_bit;
        end
        BITOP_TEST_SET: begin
          next_st.skip = tested_bit;
        end
        default: begin
          next_st.skip = 1'b0;
        end
      endcase
    end
    if (!clk_en_i) begin
      next_st = st;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{wr_en: 1'b0, wr_addr: '0, wr_data: WDATA_RST,
              skip: 1'b0, nop_cycle: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign wr_en_o = st.wr_en;
  assign wr_addr_o = st.wr_addr;
  assign wr_data_o = st.wr_data;
  assign skip_o = st.skip;
  assign nop_cycle_o = st.nop_cycle;
  assign busy_o = st.skip;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_clear_taken;
    take && op == BITOP_BIT_CLEAR;
  endsequence

  sequence s_skip_taken;
    take && ((op == BITOP_TEST_CLEAR && !tested_bit) ||
             (op == BITOP_TEST_SET && tested_bit));
  endsequence

  sequence s_flush_slot;
    skip_o && clk_en_i;
  endsequence

  a_clear_writes: assert property (
    s_clear_taken |=> wr_en_o && !wr_data_o[$past(bit_sel)] &&
      wr_addr_o == $past(faddr))
    else $error("Bit clear did not write a zero bit.");

  a_clear_keeps_others: assert property (
    s_clear_taken |=> (wr_data_o | (8'h01 << $past(bit_sel))) ==
      ($past(rd_data_i) | (8'h01 << $past(bit_sel))))
    else $error("Bit clear changed other bits.");

  a_set_writes: assert property (
    take && op == BITOP_BIT_SET |=> wr_en_o &&
      wr_data_o == ($past(rd_data_i) | (8'h01 << $past(bit_sel))))
    else $error("Bit set wrote a wrong value.");

  a_test_no_write: assert property (
    take && (op == BITOP_TEST_CLEAR || op == BITOP_TEST_SET) |=> !wr_en_o)
    else $error("Bit test wrote the register.");

  a_skip_raised: assert property (
    s_skip_taken |=> skip_o)
    else $error("Matching test did not raise the skip.");

  a_skip_sequence: assert property (
    s_skip_taken ##1 s_flush_slot |=> nop_cycle_o && !skip_o)
    else $error("Skip did not flush into one no-operation.");

  a_flush_to_nop: assert property (
    s_flush_slot |=> nop_cycle_o)
    else $error("Flush slot was not followed by a no-operation.");

  a_no_skip_single: assert property (
    take && !(op == BITOP_TEST_CLEAR && !tested_bit) &&
      !(op == BITOP_TEST_SET && tested_bit) |=> !skip_o)
    else $error("Skip raised without a matching bit.");

  a_other_ops_idle: assert property (
    take && op == BITOP_NONE |=> !wr_en_o && !skip_o)
    else $error("Unrelated opcode caused an action.");

  a_flush_discard: assert property (
    skip_o && clk_en_i |=> !wr_en_o && !skip_o)
    else $error("Discarded word was executed.");

  a_addr_range: assert property (
    rd_addr_o == instr_i[FADDR_MSB:FADDR_LSB])
    else $error("Register index not taken from low bits.");

  a_set_addr: assert property (
    take && op == BITOP_BIT_SET |=> wr_addr_o == $past(faddr))
    else $error("Bit set wrote the wrong register.");

  a_enable_freeze: assert property (
    !clk_en_i |=> $stable(wr_en_o) && $stable(wr_addr_o) &&
      $stable(wr_data_o) && $stable(skip_o) && $stable(nop_cycle_o))
    else $error("State moved while the enable was low.");

  a_nop_single: assert property (
    nop_cycle_o && clk_en_i |=> !nop_cycle_o)
    else $error("No-operation slot lasted more than one cycle.");

  // Checked with reset itself, so the default disable is overridden.
  a_reset_quiet: assert property (disable iff (1'b0)
    $fell(reset_i) |-> !wr_en_o && !skip_o && !nop_cycle_o)
    else $error("Outputs active at reset release.");

  a_write_pulse: assert property (
    wr_en_o && clk_en_i &&
      !(take && (op == BITOP_BIT_CLEAR || op == BITOP_BIT_SET)) |=> !wr_en_o)
    else $error("Write strobe stood longer than one cycle.");

  a_test_keeps_data: assert property (
    take && (op == BITOP_TEST_CLEAR || op == BITOP_TEST_SET) |=>
      $stable(wr_data_o) && $stable(wr_addr_o))
    else $error("Bit test disturbed the write-back value.");

  a_mask_onehot: assert property (
    $onehot(bit_mask))
    else $error("Bit select is not one-hot.");

  a_tested_bit: assert property (
    tested_bit == rd_data_i[bit_sel])
    else $error("Tested bit does not match the selected bit.");

  a_nop_no_write: assert property (
    nop_cycle_o |-> !wr_en_o)
    else $error("Write issued in the no-operation slot.");

  a_skip_no_write: assert property (
    skip_o |-> !wr_en_o)
    else $error("Write issued together with a skip.");
endmodule // bitop_unit

/* File: verif/bitop_tb.sv */
// Testbench for the bit-oriented instruction unit: corner and random words.
// Assumes registered answers one cycle after each taken word.
`timescale 1ns/1ps
module testbench;
  import bitop_pkg::*;
  logic sys_clk_i = 0;
  logic reset_i = 1;
  logic clk_en_i = 0;
  logic instr_valid_i = 0;
  logic [INSTR_W-1:0] instr_i = NOP_WORD;
  logic [DATA_W-1:0] rd_data_i = 8'h00;
  logic [FADDR_W-1:0] rd_addr_o, wr_addr_o, e_addr;
  logic [DATA_W-1:0] wr_data_o, e_data;
  logic wr_en_o, skip_o, nop_cycle_o, busy_o, e_wr, e_skip, e_nop;
  logic [31:0] r;
  integer seed = 97;
  integer bad_count = 0;
  integer num_checks = 0;
  integer i;

  bitop_unit u_bitop_unit (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .wr_en_o(wr_en_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .skip_o(skip_o),
    .nop_cycle_o(nop_cycle_o), .busy_o(busy_o));

  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  function automatic logic [7:0] new_data(logic [11:0] w, logic [7:0] d);
    if (w[11:8] == OPC_BIT_CLEAR) return d & ~(8'h01 << w[7:5]);
    return d | (8'h01 << w[7:5]);
  endfunction

  function automatic logic skips(logic [11:0] w, logic [7:0] d);
    return (w[11:8] == OPC_TEST_CLEAR && !d[w[7:5]]) ||
      (w[11:8] == OPC_TEST_SET && d[w[7:5]]);
  endfunction

  task automatic step(input logic en, input logic v, input logic [11:0] w,
                      input logic [7:0] d);
    logic tk;
    clk_en_i = en;
    instr_valid_i = v;
    instr_i = w;
    rd_data_i = d;
    #1 check(rd_addr_o, w[4:0]);
    tk = v && !e_skip;
    if (en) begin
      e_nop = e_skip;
      e_wr = tk && (w[11:8] == OPC_BIT_CLEAR || w[11:8] == OPC_BIT_SET);
      e_skip = tk && skips(w, d);
      if (e_wr) begin
        e_addr = w[4:0];
        e_data = new_data(w, d);
      end
    end
    @(posedge sys_clk_i);
    #2 check(wr_en_o, e_wr);
    if (e_wr) begin
      check(wr_addr_o, e_addr);
      check(wr_data_o, e_data);
    end
    check(skip_o, e_skip);
    check(nop_cycle_o, e_nop);
    check(busy_o, e_skip);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {e_wr, e_skip, e_nop, e_addr, e_data} = '0;
    repeat (5) @(posedge sys_clk_i);
    #2 reset_i = 0;
    check({wr_en_o, skip_o, nop_cycle_o}, 8'h00);
    step(1, 1, 12'h4E3, 8'hC7);
    step(1, 1, 12'h5E3, 8'h0A);
    step(1, 1, 12'h4FF, 8'hFF);
    step(1, 1, 12'h623, 8'hFD);
    step(1, 1, 12'h5FF, 8'h00);
    step(1, 1, 12'h723, 8'h02);
    step(1, 1, 12'h7E0, 8'h80);
    step(1, 1, 12'h623, 8'h02);
    step(1, 1, 12'h703, 8'hFE);
    step(1, 1, 12'h3E3, 8'h00);
    step(1, 1, 12'h400, 8'h01);
    step(0, 1, 12'h500, 8'h00);
    step(1, 0, 12'h500, 8'h00);
    $display("corner tests done");
    for (i = 0; i < 600; i = i + 1) begin
      r = $random(seed);
      step(r[31:29] != 3'h0, r[28:27] != 2'h0,
           {r[26] ? 2'b01 : r[25:24], r[9:0]}, r[23:16]);
    end
    $display("random tests done");
    give_verdict();
  end
endmodule // testbench
